// ==== bpio_map.vh ====
// register offsets, field positions and reset values of the port block
`ifndef BPIO_MAP_VH
`define BPIO_MAP_VH
// ==========================================================
// register offsets
`define BPIO_OFS_A_DATA 4'h0
`define BPIO_OFS_A_DIR 4'h1
`define BPIO_OFS_B_DATA 4'h2
`define BPIO_OFS_B_DIR 4'h3
`define BPIO_OFS_C_DATA 4'h4
`define BPIO_OFS_C_DIR 4'h5
`define BPIO_OFS_WAKE_EN 4'h6
`define BPIO_OFS_IRQ_CTL 4'h7
`define BPIO_OFS_CNT_CTL 4'h8
`define BPIO_OFS_BITOP 4'h9
`define BPIO_OFS_IRQ_STAT 4'hA
`define BPIO_OFS_IRQ_MASK 4'hB
// ==========================================================
// reset values
`define BPIO_RST_PORT 8'hFF
`define BPIO_RST_ZERO 8'h00
// ==========================================================
// field positions
`define BPIO_IRQ_CTL_GLOBAL 0
`define BPIO_IRQ_CTL_EXT 1
`define BPIO_CNT_MODE_HI 7
`define BPIO_CNT_MODE_LO 6
`define BPIO_CNT_MODE_OFF 2'h0
`define BPIO_CNT_MODE_EVENT 2'h1
`define BPIO_CNT_MODE_TIMER 2'h2
`define BPIO_CNT_MODE_PWM 2'h3
`define BPIO_BITOP_SET 7
`define BPIO_BITOP_REG_HI 6
`define BPIO_BITOP_REG_LO 4
`define BPIO_BITOP_IDX_HI 2
`define BPIO_BITOP_IDX_LO 0
`define BPIO_ST_WAKE 0
`define BPIO_ST_EXT 1
// bit-op state codes, one-hot
`define BPIO_S_IDLE 3'h1
`define BPIO_S_READ 3'h2
`define BPIO_S_WRITE 3'h4
`endif

// ==== bpio_port.v ====
// three bidirectional ports with shared functions, wake and irq status
//
// Contract
// - direction bit one makes pin input
// - direction bit zero drives latch out
// - one direction bit per pin
// - output pins read back latch value
// - tone out needs option and output
// - ext irq pin only when enabled
// - counter pin needs event mode, input (code also enables it in pwm mode)
// - off or timer mode frees pin
// - reset sets data and direction ones
// - bit op reads, modifies, writes byte
// - falling edge on enabled pin wakes
// - counter pin pull-up by option only
// - pad sampled at read, not latched
// - latch holds until next write
// - pull-up option covers whole port
//
// The address-and-strobe port and the register addresses were left to the implementer.
`include "bpio_map.vh"
module bpio_port #(
  parameter W = 8
) (
  // clock and reset
  input wire clock_i,
  input wire reset_i,
  // register port
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  // fixed options
  input wire tone_opt_i,
  input wire [2:0] pull_opt_i,
  // power down and tone source
  input wire power_down_i,
  input wire tone_i,
  // pads
  input wire [W-1:0] pad_a_i,
  input wire [W-1:0] pad_b_i,
  input wire [W-1:0] pad_c_i,
  output reg [W-1:0] out_a_o,
  output reg [W-1:0] out_b_o,
  output reg [W-1:0] out_c_o,
  output reg [W-1:0] oe_a_o,
  output reg [W-1:0] oe_b_o,
  output reg [W-1:0] oe_c_o,
  output reg [W-1:0] pu_a_o,
  output reg [W-1:0] pu_b_o,
  output reg [W-1:0] pu_c_o,
  // shared functions
  output reg ext_irq_n_o,
  output reg counter_event_pin_o,
  output reg wake_o,
  output reg irq_o
);

// ==========================================================
// registers
reg [W-1:0] first_port_output_latch_r;
reg [W-1:0] second_port_output_latch_r;
reg [W-1:0] third_port_output_latch_r;
reg [W-1:0] first_port_direction_r;
reg [W-1:0] second_port_direction_r;
reg [W-1:0] third_port_direction_r;
reg [W-1:0] wake_en_r;
reg [7:0] irq_control_reg_r;
reg [7:0] counter_control_reg_r;
reg [1:0] irq_stat_r;
reg [1:0] irq_mask_r;
reg [W-1:0] pad_a_prev_r;
reg [2:0] bop_state_r;
reg [7:0] bop_cmd_r;
reg [W-1:0] bop_byte_r;

// bit-op sequencer states, one-hot
localparam [2:0] BOP_IDLE = `BPIO_S_IDLE;
localparam [2:0] BOP_READ = `BPIO_S_READ;
localparam [2:0] BOP_WRITE = `BPIO_S_WRITE;

// ==========================================================
// readback: inputs show pad, outputs show latch
function [W-1:0] bpio_mix;
  input [W-1:0] dir;
  input [W-1:0] latch;
  input [W-1:0] pad;
  begin
    bpio_mix = (dir & pad) | (~dir & latch);
  end
endfunction

function [7:0] bpio_view;
  input [3:0] a;
  begin
    case (a)
      `BPIO_OFS_A_DATA: bpio_view = bpio_mix(first_port_direction_r,
        first_port_output_latch_r, pad_a_i);
      `BPIO_OFS_B_DATA: bpio_view = bpio_mix(second_port_direction_r,
        second_port_output_latch_r, pad_b_i);
      `BPIO_OFS_C_DATA: bpio_view = bpio_mix(third_port_direction_r,
        third_port_output_latch_r, pad_c_i);
      `BPIO_OFS_A_DIR: bpio_view = first_port_direction_r;
      `BPIO_OFS_B_DIR: bpio_view = second_port_direction_r;
      `BPIO_OFS_C_DIR: bpio_view = third_port_direction_r;
      `BPIO_OFS_WAKE_EN: bpio_view = wake_en_r;
      `BPIO_OFS_IRQ_CTL: bpio_view = irq_control_reg_r;
      `BPIO_OFS_CNT_CTL: bpio_view = counter_control_reg_r;
      `BPIO_OFS_BITOP: bpio_view = {7'h00, bop_state_r != BOP_IDLE};
      `BPIO_OFS_IRQ_STAT: bpio_view = {6'h00, irq_stat_r};
      `BPIO_OFS_IRQ_MASK: bpio_view = {6'h00, irq_mask_r};
      default: bpio_view = 8'h00;
    endcase
  end
endfunction

// ==========================================================
// bit operation sequencer
wire [3:0] bop_addr;
wire [2:0] bop_idx;
wire bop_wr;
reg [W-1:0] bop_new;
assign bop_addr = {1'b0, bop_cmd_r[`BPIO_BITOP_REG_HI:`BPIO_BITOP_REG_LO]};
assign bop_idx = bop_cmd_r[`BPIO_BITOP_IDX_HI:`BPIO_BITOP_IDX_LO];
assign bop_wr = (bop_state_r == BOP_WRITE);

always @* begin
  bop_new = bop_byte_r;
  bop_new[bop_idx] = bop_cmd_r[`BPIO_BITOP_SET];
end

// a command written while busy is dropped, not queued
always @(posedge clock_i) begin
  if (reset_i) begin
    bop_state_r <= BOP_IDLE;
    bop_cmd_r <= 8'h00;
    bop_byte_r <= {W{1'b0}};
  end else begin
    case (bop_state_r)
      BOP_IDLE: begin
        if (wr_i && addr_i == `BPIO_OFS_BITOP) begin
          bop_cmd_r <= wdata_i;
          bop_state_r <= BOP_READ;
        end
      end
      BOP_READ: begin
        // whole byte, data ports give the pad/latch mix
        bop_byte_r <= bpio_view(bop_addr);
        bop_state_r <= BOP_WRITE;
      end
      BOP_WRITE: bop_state_r <= BOP_IDLE;
      default: bop_state_r <= BOP_IDLE;
    endcase
  end
end

// ==========================================================
// register writes
// the bit op lands first; a bus write to the same register in
// that cycle overrides it, writes to other registers keep both
always @(posedge clock_i) begin
  if (reset_i) begin
    first_port_output_latch_r <= `BPIO_RST_PORT;
    second_port_output_latch_r <= `BPIO_RST_PORT;
    third_port_output_latch_r <= `BPIO_RST_PORT;
    first_port_direction_r <= `BPIO_RST_PORT;
    second_port_direction_r <= `BPIO_RST_PORT;
    third_port_direction_r <= `BPIO_RST_PORT;
    wake_en_r <= `BPIO_RST_ZERO;
    irq_control_reg_r <= `BPIO_RST_ZERO;
    counter_control_reg_r <= `BPIO_RST_ZERO;
    irq_mask_r <= 2'h0;
  end else begin
    if (bop_wr) begin
      case (bop_addr)
        `BPIO_OFS_A_DATA: first_port_output_latch_r <= bop_new;
        `BPIO_OFS_B_DATA: second_port_output_latch_r <= bop_new;
        `BPIO_OFS_C_DATA: third_port_output_latch_r <= bop_new;
        `BPIO_OFS_A_DIR: first_port_direction_r <= bop_new;
        `BPIO_OFS_B_DIR: second_port_direction_r <= bop_new;
        `BPIO_OFS_C_DIR: third_port_direction_r <= bop_new;
        `BPIO_OFS_WAKE_EN: wake_en_r <= bop_new;
        `BPIO_OFS_IRQ_CTL: irq_control_reg_r <= bop_new;
        default: counter_control_reg_r <= counter_control_reg_r;
      endcase
    end
    if (wr_i) begin
      case (addr_i)
        `BPIO_OFS_A_DATA: first_port_output_latch_r <= wdata_i;
        `BPIO_OFS_B_DATA: second_port_output_latch_r <= wdata_i;
        `BPIO_OFS_C_DATA: third_port_output_latch_r <= wdata_i;
        `BPIO_OFS_A_DIR: first_port_direction_r <= wdata_i;
        `BPIO_OFS_B_DIR: second_port_direction_r <= wdata_i;
        `BPIO_OFS_C_DIR: third_port_direction_r <= wdata_i;
        `BPIO_OFS_WAKE_EN: wake_en_r <= wdata_i;
        `BPIO_OFS_IRQ_CTL: irq_control_reg_r <= wdata_i;
        `BPIO_OFS_CNT_CTL: counter_control_reg_r <= wdata_i;
        `BPIO_OFS_IRQ_MASK: irq_mask_r <= wdata_i[1:0];
        default: irq_mask_r <= irq_mask_r;
      endcase
    end
  end
end

// ==========================================================
// read data, one cycle after strobe
always @(posedge clock_i) begin
  if (reset_i) begin
    rdata_o <= 8'h00;
  end else if (rd_i) begin
    rdata_o <= bpio_view(addr_i);
  end else begin
    rdata_o <= 8'h00;
  end
end

// ==========================================================
// pin drive, tone muxing, pull-ups
wire [1:0] cnt_mode;
wire ext_en;
wire cnt_pin_en;
wire [W-1:0] b_out;
assign cnt_mode =
  counter_control_reg_r[`BPIO_CNT_MODE_HI:`BPIO_CNT_MODE_LO];
assign ext_en = irq_control_reg_r[`BPIO_IRQ_CTL_GLOBAL] &
  irq_control_reg_r[`BPIO_IRQ_CTL_EXT];
assign cnt_pin_en = third_port_direction_r[1] &
  (cnt_mode == `BPIO_CNT_MODE_EVENT || cnt_mode == `BPIO_CNT_MODE_PWM);
assign b_out = tone_opt_i ?
  {second_port_output_latch_r[W-1:2], ~tone_i, tone_i} :
  second_port_output_latch_r;

// ==========================================================
// per-pin enables, one slice per pin
wire [W-1:0] oe_a_nxt;
wire [W-1:0] oe_b_nxt;
wire [W-1:0] oe_c_nxt;
wire [W-1:0] pu_a_nxt;
wire [W-1:0] pu_b_nxt;
wire [W-1:0] pu_c_nxt;
genvar gi;
generate
  for (gi = 0; gi < W; gi = gi + 1) begin : g_pin
    // direction one is input, so the driver is off
    assign oe_a_nxt[gi] = ~first_port_direction_r[gi];
    assign oe_b_nxt[gi] = ~second_port_direction_r[gi];
    assign oe_c_nxt[gi] = ~third_port_direction_r[gi];
    // port-wide option, gated per pin by direction
    assign pu_a_nxt[gi] = pull_opt_i[0] & first_port_direction_r[gi];
    assign pu_b_nxt[gi] = pull_opt_i[1] & second_port_direction_r[gi];
    assign pu_c_nxt[gi] = pull_opt_i[2] & third_port_direction_r[gi];
  end
endgenerate

always @(posedge clock_i) begin
  if (reset_i) begin
    out_a_o <= `BPIO_RST_PORT;
    out_b_o <= `BPIO_RST_PORT;
    out_c_o <= `BPIO_RST_PORT;
    oe_a_o <= {W{1'b0}};
    oe_b_o <= {W{1'b0}};
    oe_c_o <= {W{1'b0}};
    pu_a_o <= {W{1'b0}};
    pu_b_o <= {W{1'b0}};
    pu_c_o <= {W{1'b0}};
    ext_irq_n_o <= 1'b1;
    counter_event_pin_o <= 1'b0;
  end else begin
    out_a_o <= first_port_output_latch_r;
    out_b_o <= b_out;
    out_c_o <= third_port_output_latch_r;
    oe_a_o <= oe_a_nxt;
    oe_b_o <= oe_b_nxt;
    oe_c_o <= oe_c_nxt;
    pu_a_o <= pu_a_nxt;
    pu_b_o <= pu_b_nxt;
    pu_c_o <= pu_c_nxt;
    ext_irq_n_o <= ext_en ? pad_c_i[0] : 1'b1;
    counter_event_pin_o <= cnt_pin_en & pad_c_i[1];
  end
end

// ==========================================================
// wake detect and interrupt status
// previous levels reset low, so no false edge follows reset
function [1:0] bpio_w1c;
  input [1:0] cur;
  input [1:0] clear;
  input [1:0] set;
  begin
    // set wins over a clear in the same cycle
    bpio_w1c = (cur & ~clear) | set;
  end
endfunction

wire [W-1:0] fall_a;
wire wake_ev;
assign fall_a = pad_a_prev_r & ~pad_a_i & wake_en_r;
assign wake_ev = power_down_i & (|fall_a);

reg ext_prev_r;
wire ext_fall;
assign ext_fall = ext_en & ext_prev_r & ~pad_c_i[0];
wire [1:0] ev;
wire [1:0] clr;
wire [1:0] stat_nxt;
assign ev = {ext_fall, wake_ev};
assign clr = (wr_i && addr_i == `BPIO_OFS_IRQ_STAT) ? wdata_i[1:0] : 2'h0;
assign stat_nxt = bpio_w1c(irq_stat_r, clr, ev);

always @(posedge clock_i) begin
  if (reset_i) begin
    pad_a_prev_r <= {W{1'b0}};
    ext_prev_r <= 1'b0;
    irq_stat_r <= 2'h0;
    wake_o <= 1'b0;
    irq_o <= 1'b0;
  end else begin
    pad_a_prev_r <= pad_a_i;
    ext_prev_r <= pad_c_i[0];
    irq_stat_r <= stat_nxt;
    wake_o <= wake_ev;
    // level, follows the status register it is built from
    irq_o <= |(stat_nxt & irq_mask_r);
  end
end

endmodule

// ==== bpio_port_asserts.sv ====
// checker for the port block
module bpio_port_asserts #(parameter W = 8) (
  // clock, reset, bus
  input logic clock_i,
  input logic reset_i,
  input logic rd_i,
  input logic [7:0] rdata_o,
  // options and pins
  input logic tone_opt_i,
  input logic tone_i,
  input logic [2:0] pull_opt_i,
  input logic power_down_i,
  input logic [W-1:0] pad_c_i,
  input logic [W-1:0] out_a_o,
  input logic [W-1:0] oe_a_o,
  input logic [W-1:0] pu_a_o,
  input logic [W-1:0] out_b_o,
  input logic [W-1:0] oe_b_o,
  input logic ext_irq_n_o,
  input logic counter_event_pin_o,
  input logic wake_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  a_rd_idle: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("rdata not idle");
  a_pu_in_only: assert property ((pu_a_o & oe_a_o) == '0)
    else $error("pull-up on output");
  a_pu_opt_off: assert property (!pull_opt_i[0] |=> pu_a_o == '0)
    else $error("pull-up without option");
  a_reset_pins: assert property ($fell(reset_i) |->
    out_a_o == '1 && oe_a_o == '0) else $error("pins not at reset");
  a_tone_drive: assert property (tone_opt_i && oe_b_o[0] |->
    out_b_o[0] == $past(tone_i)) else $error("tone not driven");
  a_ext_idle: assert property (pad_c_i[0] |=> ext_irq_n_o)
    else $error("ext request without low pad");
  a_cnt_low: assert property (!pad_c_i[1] |=> !counter_event_pin_o)
    else $error("counter pin without pad");
  a_wake_pd: assert property (!power_down_i |=> !wake_o)
    else $error("wake outside power down");
endmodule

// ==== bpio_pads.sv ====
// pin model: drivers, switches, pull-ups, floating lines
module bpio_pads (
  // clock and block side
  input logic clock_i,
  input logic [7:0] out_i,
  input logic [7:0] oe_i,
  input logic [7:0] pu_i,
  // external switches
  input logic [7:0] drv_i,
  input logic [7:0] val_i,
  output logic [7:0] pad_o
);
  logic [7:0] flt_r = 8'h55;
  // undriven lines without pull-up toggle so a stale level never looks valid
  always @(posedge clock_i) flt_r <= ~flt_r;
  assign pad_o = (oe_i & out_i) | (~oe_i & drv_i & val_i)
    | (~oe_i & ~drv_i & (pu_i | flt_r));
endmodule

// ==== tb_bpio_port.sv ====
// testbench for the port block
module tb_bpio_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 0, reset_i = 1, wr_i = 0, rd_i = 0, tone_i = 0;
  logic power_down_i = 0, tone_opt_i = 1, i0;
  logic [2:0] pull_opt_i = 3'h0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00, dva = 8'hFF, vva = 8'hC3, vvc = 8'hFF;
  wire [7:0] pad_a_i, pad_b_i, pad_c_i, rdata_o, out_a_o, out_b_o, out_c_o;
  wire [7:0] oe_a_o, oe_b_o, oe_c_o, pu_a_o, pu_b_o, pu_c_o;
  wire ext_irq_n_o, counter_event_pin_o, wake_o, irq_o;
  int fails = 0, cmp_count = 0;
  logic seen_wake = 0;
  always @(posedge clock_i) if (wake_o) seen_wake <= 1'b1;
  bpio_port u_dut(.clock_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .tone_opt_i, .pull_opt_i, .power_down_i, .tone_i, .pad_a_i,
    .pad_b_i, .pad_c_i, .out_a_o, .out_b_o, .out_c_o, .oe_a_o, .oe_b_o,
    .oe_c_o, .pu_a_o, .pu_b_o, .pu_c_o, .ext_irq_n_o, .counter_event_pin_o,
    .wake_o, .irq_o);
  bpio_pads u_pa(.clock_i, .out_i(out_a_o), .oe_i(oe_a_o), .pu_i(pu_a_o),
    .drv_i(dva), .val_i(vva), .pad_o(pad_a_i));
  bpio_pads u_pb(.clock_i, .out_i(out_b_o), .oe_i(oe_b_o), .pu_i(pu_b_o),
    .drv_i(8'hFF), .val_i(8'h00), .pad_o(pad_b_i));
  bpio_pads u_pc(.clock_i, .out_i(out_c_o), .oe_i(oe_c_o), .pu_i(pu_c_o),
    .drv_i(8'hFF), .val_i(vvc), .pad_o(pad_c_i));
  task chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_i) wr_i <= 1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i) wr_i <= 0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock_i) rd_i <= 1;
    addr_i <= a;
    @(posedge clock_i) rd_i <= 0;
    @(negedge clock_i) chk(rdata_o, e);
  endtask
  task settle;
    repeat (3) @(posedge clock_i);
    @(negedge clock_i);
  endtask
  task t_dir;
    rd(4'h1, 8'hFF);
    wr(4'h1, 8'h0F);
    settle;
    chk(out_a_o, 8'hFF);
    chk(oe_a_o, 8'hF0);
    wr(4'h0, 8'h5A);
    rd(4'h0, 8'h53);
    @(posedge clock_i) vva <= 8'h3C;
    settle;
    chk(out_a_o, 8'h5A);
    rd(4'h0, 8'h5C);
  endtask
  task t_pull;
    @(posedge clock_i) pull_opt_i <= 3'h1;
    dva <= 8'h00;
    settle;
    chk(pu_a_o, 8'h0F);
    rd(4'h0, 8'h5F);
    @(posedge clock_i) pull_opt_i <= 3'h7;
    settle;
    chk(pu_b_o, 8'hFF);
    chk(pu_c_o, 8'hFF);
    @(posedge clock_i) dva <= 8'hFF;
  endtask
  task t_bitop;
    wr(4'h9, 8'h94);
    settle;
    rd(4'h1, 8'h1F);
    wr(4'h9, 8'h00);
    settle;
    wr(4'h1, 8'h00);
    settle;
    chk(out_a_o, 8'h5C);
    wr(4'h1, 8'h0F);
  endtask
  task t_wake;
    wr(4'h6, 8'h01);
    @(posedge clock_i) vva <= 8'h03;
    power_down_i <= 1;
    settle;
    @(posedge clock_i) vva <= 8'h01;
    settle;
    rd(4'hA, 8'h00);
    chk({7'h00, seen_wake}, 8'h00);
    @(posedge clock_i) vva <= 8'h00;
    settle;
    rd(4'hA, 8'h01);
    chk({7'h00, seen_wake}, 8'h01);
    wr(4'hB, 8'h00);
    settle;
    i0 = irq_o;
    wr(4'hB, 8'hFF);
    settle;
    chk({7'h00, i0 ^ irq_o}, 8'h01);
    wr(4'hA, 8'h01);
    settle;
    chk({7'h00, irq_o}, 8'h00);
    rd(4'hA, 8'h00);
    @(posedge clock_i) power_down_i <= 0;
  endtask
  task t_share;
    wr(4'h7, 8'h03);
    @(posedge clock_i) vvc <= 8'hFC;
    settle;
    chk({7'h00, ext_irq_n_o}, 8'h00);
    wr(4'h7, 8'h00);
    settle;
    chk({7'h00, ext_irq_n_o}, 8'h01);
    @(posedge clock_i) vvc <= 8'hFE;
    for (int m = 0; m < 4; m++) begin
      wr(4'h8, {m[1:0], 6'h00});
      settle;
      chk({7'h00, counter_event_pin_o}, {7'h00, m[0]});
    end
    wr(4'h5, 8'hFD);
    settle;
    chk({7'h00, counter_event_pin_o}, 8'h00);
    chk(oe_c_o, 8'h02);
    chk(out_c_o, 8'hFF);
    chk(pu_c_o, 8'hFD);
    rd(4'hF, 8'h00);
  endtask
  task t_tone;
    wr(4'h3, 8'hFC);
    @(posedge clock_i) tone_i <= 1;
    settle;
    chk(out_b_o & 8'h03, 8'h01);
    @(posedge clock_i) tone_opt_i <= 0;
    settle;
    chk(out_b_o & 8'h03, 8'h03);
    @(posedge clock_i) tone_opt_i <= 1;
    wr(4'h3, 8'hFF);
    settle;
    chk(oe_b_o, 8'h00);
    rd(4'h2, 8'h00);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial forever #2.5 clock_i = ~clock_i;
  initial begin
    repeat (8) @(posedge clock_i);
    reset_i <= 0;
    t_dir;
    t_pull;
    t_bitop;
    t_wake;
    t_share;
    t_tone;
    finish_test;
  end
  initial begin
    #20000;
    fails++;
    finish_test;
  end
endmodule
bind bpio_port bpio_port_asserts #(.W(W)) u_chk(.clock_i, .reset_i,
  .rd_i, .rdata_o, .tone_opt_i, .tone_i, .pull_opt_i, .power_down_i,
  .pad_c_i, .out_a_o, .oe_a_o, .pu_a_o, .out_b_o, .oe_b_o, .ext_irq_n_o,
  .counter_event_pin_o, .wake_o);
